// >>> logic/sec_top.sv
/*
 * EEPROM command and busy handshake: register file, MAC auto-load, engine control.
 * Assumes an Avalon-MM master with byte addresses and a serial EEPROM on four pins.
 */
`timescale 1ns/1ps
module sec_top
	import sec_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
	input  wire logic        mclk_in,
	input  wire logic        rst_in,
	input  wire logic [7:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic             avs_waitrequest_out,
	output logic [31:0]      avs_readdata_out,
	input  wire logic        eeprom_do_in,
	output logic             eeprom_cs_out,
	output logic             eeprom_sck_out,
	output logic             eeprom_di_out,
	output logic [47:0]      mac_addr_out,
	output logic             mac_valid_out
);
	typedef enum logic [3:0] {
		ST_LOAD  = 4'b0001,
		ST_LWAIT = 4'b0010,
		ST_IDLE  = 4'b0100,
		ST_BUSY  = 4'b1000
	} sec_st_t;

	sec_st_t     state;
	logic        eeprom_op_pending;
	logic        eeprom_op_timeout;
	logic [2:0]  eeprom_op_select;
	logic [7:0]  eeprom_op_addr;
	logic [7:0]  eeprom_data_word;
	logic [2:0]  mac_idx;
	logic [7:0]  mac_mem [MAC_BYTES];
	logic [31:0] cmd_view;
	logic [31:0] rd_mux;
	logic        wr_take;
	logic        wr_cmd;
	logic        wr_data;
	logic        host_go;
	logic [31:0] cmd_merged;
	logic        eng_start;
	logic        eng_done;
	sec_cmd_t    eng_cmd;
	sec_rsp_t    eng_rsp;

	function automatic logic [31:0] be_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i])
				r[i*8 +: 8] = new_v[i*8 +: 8];
		end
		return r;
	endfunction : be_merge

	sec_avmm_slave u_bus (
		.mclk_in         (mclk_in),
		.rst_in          (rst_in),
		.read_in         (avs_read_in),
		.write_in        (avs_write_in),
		.rdata_in        (rd_mux),
		.waitrequest_out (avs_waitrequest_out),
		.readdata_out    (avs_readdata_out),
		.wr_take_out     (wr_take)
	);

	sec_serial_engine #(
		.TIMEOUT_CYCLES (TIMEOUT_CYCLES)
	) u_eng (
		.mclk_in        (mclk_in),
		.rst_in         (rst_in),
		.start_in       (eng_start),
		.cmd_in         (eng_cmd),
		.eeprom_do_in   (eeprom_do_in),
		.eeprom_cs_out  (eeprom_cs_out),
		.eeprom_sck_out (eeprom_sck_out),
		.eeprom_di_out  (eeprom_di_out),
		.done_out       (eng_done),
		.rsp_out        (eng_rsp)
	);

	always_comb begin
		cmd_view = 32'h0000_0000;
		cmd_view[CMD_PEND_BIT] = eeprom_op_pending;
		cmd_view[CMD_OP_HI:CMD_OP_LO] = eeprom_op_select;
		cmd_view[CMD_TMO_BIT] = eeprom_op_timeout;
		cmd_view[CMD_ADDR_HI:CMD_ADDR_LO] = eeprom_op_addr;
	end

	// Unmapped offsets read as zero and ignore writes
	always_comb begin
		unique case (avs_address_in)
			REG_CMD_OFS:  rd_mux = cmd_view;
			REG_DATA_OFS: rd_mux = {24'h00_0000, eeprom_data_word};
			default:      rd_mux = 32'h0000_0000;
		endcase
	end

	assign wr_cmd  = wr_take && avs_address_in == REG_CMD_OFS;
	assign wr_data = wr_take && avs_address_in == REG_DATA_OFS;

	// A new command is taken only when idle; a write while pending is dropped
	assign cmd_merged = be_merge(cmd_view, avs_writedata_in, avs_byteenable_in);
	assign host_go = wr_cmd && state == ST_IDLE
		&& cmd_merged[CMD_PEND_BIT]; // see R1 R4

	always_comb begin
		eng_start = 1'b0;
		eng_cmd.op = eeprom_op_select;
		eng_cmd.addr = eeprom_op_addr;
		eng_cmd.wdata = eeprom_data_word;
		if (state == ST_LOAD) begin
			eng_start = 1'b1;
			eng_cmd.op = SEC_OP_READ;
			eng_cmd.addr = MAC_BASE_ADDR + {5'h00, mac_idx}; // see R7
		end else if (host_go) begin
			eng_start = 1'b1;
			eng_cmd.op = avs_writedata_in[CMD_OP_HI:CMD_OP_LO];
			eng_cmd.addr = avs_writedata_in[CMD_ADDR_HI:CMD_ADDR_LO];
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			state   <= ST_LOAD;
			mac_idx <= 3'h0;
		end else begin
			unique case (state)
				ST_LOAD:  state <= ST_LWAIT;
				ST_LWAIT: if (eng_done) begin
					// Missing EEPROM still ends the load; the read byte is just kept
					if (mac_idx == 3'(MAC_BYTES - 1)) begin
						state <= ST_IDLE; // see R7
					end else begin
						mac_idx <= mac_idx + 3'h1;
						state   <= ST_LOAD;
					end
				end
				ST_IDLE: if (host_go)
					state <= ST_BUSY;
				ST_BUSY: if (eng_done)
					state <= ST_IDLE;
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Reset value shows busy for the auto-load
	always_ff @(posedge mclk_in) begin
		if (rst_in)
			eeprom_op_pending <= CMD_RESET[CMD_PEND_BIT]; // see R6
		else if (host_go)
			eeprom_op_pending <= 1'b1; // see R1
		else if (eng_done && (state == ST_BUSY
			|| (state == ST_LWAIT && mac_idx == 3'(MAC_BYTES - 1))))
			eeprom_op_pending <= 1'b0; // see R2 R5 R7
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			eeprom_op_select <= CMD_RESET[CMD_OP_HI:CMD_OP_LO];
			eeprom_op_addr   <= CMD_RESET[CMD_ADDR_HI:CMD_ADDR_LO];
		end else if (host_go) begin
			eeprom_op_select <= avs_writedata_in[CMD_OP_HI:CMD_OP_LO];
			eeprom_op_addr   <= avs_writedata_in[CMD_ADDR_HI:CMD_ADDR_LO];
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in)
			eeprom_op_timeout <= CMD_RESET[CMD_TMO_BIT];
		else if (host_go)
			eeprom_op_timeout <= 1'b0;
		else if (eng_done && state == ST_BUSY && eng_rsp.timeout)
			eeprom_op_timeout <= 1'b1; // see R5
	end

	// Engine result lands in the same edge that clears the pending flag
	always_ff @(posedge mclk_in) begin
		if (rst_in)
			eeprom_data_word <= DATA_RESET;
		else if (eng_done && state == ST_BUSY && eeprom_op_select == SEC_OP_READ)
			eeprom_data_word <= eng_rsp.rdata; // see R3
		else if (wr_data && avs_byteenable_in[0] && state == ST_IDLE)
			eeprom_data_word <= avs_writedata_in[7:0]; // see R4
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			for (int i = 0; i < MAC_BYTES; i++)
				mac_mem[i] <= 8'h00;
		end else if (eng_done && state == ST_LWAIT) begin
			mac_mem[mac_idx] <= eng_rsp.rdata; // see R7
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			mac_addr_out  <= 48'h0000_0000_0000;
			mac_valid_out <= 1'b0;
		end else begin
			for (int i = 0; i < MAC_BYTES; i++)
				mac_addr_out[i*8 +: 8] <= mac_mem[i];
			mac_valid_out <= state == ST_IDLE || state == ST_BUSY;
		end
	end
endmodule : sec_top

// >>> common/sec_pkg.sv
/*
 * Constants and types of the serial EEPROM command handshake block.
 * Assumes one 10 MHz clock and a synchronous active-high reset.
 */
// Summary of operation
// R1 - Writing a one to bit 31 of the command register starts the selected operation at its address.
// R2 - The pending flag stays one for the whole operation and hardware clears it when done.
// R3 - On a read, valid data is in the data register by the time the pending flag clears.
// R4 - The host should not change the command or data register while the pending flag is one.
// R5 - A write with no EEPROM attached keeps the flag set until the timeout, then clears it.
// R6 - The pending flag reads one right after reset because the auto-load is running.
// R7 - After reset the MAC address is read from the EEPROM and the flag clears when that ends.
package sec_pkg;
	localparam int          CLK_MHZ       = 10;
	localparam int          CLK_NS        = 1000 / CLK_MHZ;
	localparam logic [7:0]  REG_CMD_OFS   = 8'hB0;
	localparam logic [7:0]  REG_DATA_OFS  = 8'hB4;
	localparam int          CMD_PEND_BIT  = 31;
	localparam int          CMD_OP_HI     = 30;
	localparam int          CMD_OP_LO     = 28;
	localparam int          CMD_TMO_BIT   = 9;
	localparam int          CMD_ADDR_HI   = 7;
	localparam int          CMD_ADDR_LO   = 0;
	localparam logic [31:0] CMD_RESET     = 32'h8000_0000;
	localparam logic [7:0]  DATA_RESET    = 8'h00;
	localparam int          MAC_BYTES     = 6;
	localparam logic [7:0]  MAC_BASE_ADDR = 8'h00;
	localparam int          FRAME_BITS    = 19;
	localparam int          SCK_HALF_NS   = 500;
	localparam int          SCK_HALF_CYC  = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam int          TIMEOUT_US    = 30000;
	localparam int          TIMEOUT_CYC   = TIMEOUT_US * CLK_MHZ;

	typedef enum logic [2:0] {
		SEC_OP_READ  = 3'h0,
		SEC_OP_WRITE = 3'h1
	} sec_op_t;

	typedef struct packed {
		logic [2:0] op;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sec_cmd_t;

	typedef struct packed {
		logic [7:0] rdata;
		logic       timeout;
	} sec_rsp_t;
endpackage : sec_pkg

// >>> logic/sec_avmm_slave.sv
/*
 * Avalon-MM slave front end with one wait state on every access.
 * Assumes the master holds its request until it sees waitrequest low.
 */
`timescale 1ns/1ps
module sec_avmm_slave
	import sec_pkg::*;
(
	input  wire logic        mclk_in,
	input  wire logic        rst_in,
	input  wire logic        read_in,
	input  wire logic        write_in,
	input  wire logic [31:0] rdata_in,
	output logic             waitrequest_out,
	output logic [31:0]      readdata_out,
	output logic             wr_take_out
);
	// Accept on the cycle the slave drops waitrequest; readdata is loaded alongside
	always_ff @(posedge mclk_in) begin
		if (rst_in)
			waitrequest_out <= 1'b1;
		else
			waitrequest_out <= !((read_in || write_in) && waitrequest_out);
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in)
			readdata_out <= 32'h0000_0000;
		else if (read_in && waitrequest_out)
			readdata_out <= rdata_in;
	end

	assign wr_take_out = write_in && !waitrequest_out;
endmodule : sec_avmm_slave

// >>> logic/sec_serial_engine.sv
/*
 * Serial EEPROM frame engine: shifts op, address and data out, samples data in.
 * Assumes the EEPROM drives its data line high when a write cycle is done.
 */
`timescale 1ns/1ps
module sec_serial_engine
	import sec_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
	input  wire logic     mclk_in,
	input  wire logic     rst_in,
	input  wire logic     start_in,
	input  wire sec_cmd_t cmd_in,
	input  wire logic     eeprom_do_in,
	output logic          eeprom_cs_out,
	output logic          eeprom_sck_out,
	output logic          eeprom_di_out,
	output logic          done_out,
	output sec_rsp_t      rsp_out
);
	typedef enum logic [4:0] {
		EN_IDLE  = 5'b00001,
		EN_SHIFT = 5'b00010,
		EN_GAP   = 5'b00100,
		EN_POLL  = 5'b01000,
		EN_DONE  = 5'b10000
	} sec_en_t;

	sec_en_t                 state;
	logic [FRAME_BITS-1:0]   sreg;
	logic [4:0]              bitn;
	logic [15:0]             div;
	logic [31:0]             wcnt;
	logic                    is_wr;
	logic                    tick;

	always_ff @(posedge mclk_in) begin
		if (rst_in || state == EN_IDLE)
			div <= 16'h0000;
		else if (div == 16'h0000)
			div <= 16'(SCK_HALF_CYC - 1);
		else
			div <= div - 16'h0001;
	end
	assign tick = (div == 16'h0000) && state != EN_IDLE;

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			state          <= EN_IDLE;
			sreg           <= '0;
			bitn           <= 5'h00;
			wcnt           <= 32'h0000_0000;
			is_wr          <= 1'b0;
			eeprom_cs_out  <= 1'b0;
			eeprom_sck_out <= 1'b0;
			eeprom_di_out  <= 1'b0;
			rsp_out        <= '0;
		end else begin
			unique case (state)
				EN_IDLE: if (start_in) begin
					sreg           <= cmd_in;
					bitn           <= 5'(FRAME_BITS - 1);
					is_wr          <= cmd_in.op == SEC_OP_WRITE;
					eeprom_cs_out  <= 1'b1;
					eeprom_di_out  <= cmd_in.op[2];
					rsp_out.timeout <= 1'b0;
					state          <= EN_SHIFT;
				end
				EN_SHIFT: if (tick) begin
					if (!eeprom_sck_out) begin
						eeprom_sck_out <= 1'b1;
						// Last eight samples of a frame are the read byte
						rsp_out.rdata <= {rsp_out.rdata[6:0], eeprom_do_in};
					end else begin
						eeprom_sck_out <= 1'b0;
						if (bitn == 5'h00) begin
							eeprom_cs_out <= 1'b0;
							state <= is_wr ? EN_GAP : EN_DONE;
						end else begin
							bitn          <= bitn - 5'h01;
							sreg          <= {sreg[FRAME_BITS-2:0], 1'b0};
							eeprom_di_out <= sreg[FRAME_BITS-2];
						end
					end
				end
				EN_GAP: if (tick) begin
					eeprom_cs_out <= 1'b1;
					wcnt          <= 32'h0000_0000;
					state         <= EN_POLL;
				end
				EN_POLL: begin
					if (eeprom_do_in) begin
						eeprom_cs_out <= 1'b0;
						state         <= EN_DONE;
					end else if (wcnt == 32'(TIMEOUT_CYCLES - 1)) begin // see R5
						eeprom_cs_out   <= 1'b0;
						rsp_out.timeout <= 1'b1;
						state           <= EN_DONE;
					end else begin
						wcnt <= wcnt + 32'h0000_0001;
					end
				end
				EN_DONE: state <= EN_IDLE;
				default: state <= EN_IDLE;
			endcase
		end
	end

	assign done_out = state == EN_DONE;
endmodule : sec_serial_engine

// >>> tb/sec_properties.sv
/*
 * Checker of bus timing, serial pins and MAC load of the EEPROM command block.
 * Assumes it is bound to sec_top and sees only that module's ports.
 */
`timescale 1ns/1ps
module sec_properties
	import sec_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
	input  wire logic        mclk_in,
	input  wire logic        rst_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic        avs_waitrequest_out,
	input  wire logic [31:0] avs_readdata_out,
	input  wire logic        eeprom_cs_out,
	input  wire logic        eeprom_sck_out,
	input  wire logic        eeprom_di_out,
	input  wire logic [47:0] mac_addr_out,
	input  wire logic        mac_valid_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	wait_one_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("waitrequest low for more than one cycle");
	ack_cause_a: assert property (!avs_waitrequest_out |-> avs_read_in || avs_write_in)
		else $error("waitrequest low without a request");
	// Own disable so the check runs while reset is held
	reset_state_a: assert property (disable iff (1'b0) rst_in ##1 rst_in |->
		avs_waitrequest_out && !eeprom_cs_out && !mac_valid_out && avs_readdata_out == 32'h0)
		else $error("outputs not at reset values");
	frame_start_a: assert property ($rose(eeprom_cs_out) |-> !eeprom_sck_out)
		else $error("serial clock high at frame start");
	sck_half_a: assert property ($rose(eeprom_sck_out) |-> eeprom_sck_out [*5])
		else $error("serial clock high phase too short");
	di_steady_a: assert property ($rose(eeprom_sck_out) && $past(eeprom_cs_out)
		|-> $stable(eeprom_di_out))
		else $error("serial data changed at clock rise");
	rdata_cause_a: assert property ($changed(avs_readdata_out) |-> $past(avs_read_in))
		else $error("read data changed without a read");
	mac_hold_a: assert property (mac_valid_out |=> mac_valid_out && $stable(mac_addr_out))
		else $error("MAC address changed after load");
	load_done_a: assert property ($rose(mac_valid_out) |-> !eeprom_cs_out)
		else $error("load finished during a frame");
endmodule : sec_properties
bind sec_top sec_properties #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_sec_properties (
	.mclk_in(mclk_in), .rst_in(rst_in), .avs_read_in(avs_read_in),
	.avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out),
	.avs_readdata_out(avs_readdata_out), .eeprom_cs_out(eeprom_cs_out),
	.eeprom_sck_out(eeprom_sck_out), .eeprom_di_out(eeprom_di_out),
	.mac_addr_out(mac_addr_out), .mac_valid_out(mac_valid_out));

// >>> tb/sec_eeprom_model.sv
/*
 * Behavioural serial EEPROM: 19-bit frames, MSB first, read data and write poll.
 * Assumes frames are framed by chip select and bits sampled on clock rise.
 */
`timescale 1ns/1ps
module sec_eeprom_model (
	input  wire logic cs_in,
	input  wire logic sck_in,
	input  wire logic di_in,
	input  wire logic present_in,
	input  wire logic slow_in,
	output logic      do_out
);
	logic [7:0]  mem [256];
	logic [18:0] sh;
	logic [2:0]  rop;
	logic [7:0]  ra;
	logic        rbit;
	logic        busy;
	logic        last;
	int          cnt;
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 8'(i * 37 + 8'h5A);
		{cnt, busy, rbit, last, rop} = '0;
	end
	// Absent part leaves a pulled-down line; deselected line shows the inverse of its last bit
	assign do_out = !present_in ? 1'b0 : !cs_in ? ~last : (rop == 3'h0) ? rbit : !busy;
	always @(posedge cs_in) begin
		cnt = 0;
		rop = 3'h7;
	end
	always @(posedge sck_in) if (cs_in) begin
		sh = {sh[17:0], di_in};
		cnt++;
		if (cnt == 11) {rop, ra} = sh[10:0];
	end
	always @(negedge sck_in) if (cs_in) begin
		last = do_out;
		if (cnt >= 11 && cnt < 19) rbit = mem[ra][18 - cnt];
	end
	// Write cycle: line low while busy, high once done
	always @(negedge cs_in) if (present_in && cnt == 19 && sh[18:16] == 3'h1) begin
		mem[sh[15:8]] = sh[7:0];
		busy = 1'b1;
		#(slow_in ? 20000 : 2000) busy = 1'b0;
	end
endmodule : sec_eeprom_model

// >>> tb/tb_sec_top.sv
/*
 * Self-checking bench of the EEPROM command handshake over Avalon-MM.
 * Assumes a 10 MHz clock and the behavioural EEPROM on the serial pins.
 */
`timescale 1ns/1ps
module tb_sec_top;
	import sec_pkg::*;
	localparam int TMO = 500;
	logic        mclk_in, rst_in, avs_read_in, avs_write_in, present, slow, eeprom_do;
	logic [7:0]  avs_address_in;
	logic [31:0] avs_writedata_in;
	logic [3:0]  avs_byteenable_in;
	logic        avs_waitrequest_out, mac_valid_out, cs, sck, di;
	logic [31:0] avs_readdata_out;
	logic [47:0] mac_addr_out;
	logic [7:0]  shadow [256];
	int          fails, comparisons;
	sec_top #(.TIMEOUT_CYCLES(TMO)) i_sec_top (.mclk_in(mclk_in), .rst_in(rst_in),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
		.avs_byteenable_in(avs_byteenable_in), .avs_waitrequest_out(avs_waitrequest_out),
		.avs_readdata_out(avs_readdata_out), .eeprom_do_in(eeprom_do), .eeprom_cs_out(cs),
		.eeprom_sck_out(sck), .eeprom_di_out(di), .mac_addr_out(mac_addr_out),
		.mac_valid_out(mac_valid_out));
	sec_eeprom_model i_sec_eeprom_model (.cs_in(cs), .sck_in(sck), .di_in(di),
		.present_in(present), .slow_in(slow), .do_out(eeprom_do));
	initial begin
		mclk_in = 1'b0;
		forever #50 mclk_in = ~mclk_in;
	end
	task automatic conclude();
		$display("counts: comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : conclude
	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Request held until waitrequest is sampled low; one idle edge between accesses
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge mclk_in);
		{avs_address_in, avs_writedata_in, avs_read_in, avs_write_in} <= {a, d, !wr, wr};
		for (n = 0; n < 20; n++) begin
			@(posedge mclk_in);
			if (avs_waitrequest_out === 1'b0) break;
		end
		q = avs_readdata_out;
		{avs_read_in, avs_write_in} <= 2'b00;
		if (n == 20) begin
			fails++;
			conclude();
		end
	endtask : bus
	task automatic wait_idle(output int n);
		logic [31:0] q;
		q = 32'hFFFF_FFFF;
		for (n = 0; n < 400 && q[31] !== 1'b0; n++) bus(0, REG_CMD_OFS, 32'h0, q);
		if (q[31] !== 1'b0) begin
			fails++;
			conclude();
		end
		n = n * 3;
	endtask : wait_idle
	task automatic run_op(input logic [2:0] o, input logic [7:0] a, input logic [7:0] d,
		output int n);
		logic [31:0] q;
		bus(1, REG_DATA_OFS, {24'h0, d}, q);
		bus(1, REG_CMD_OFS, {1'b1, o, 20'h0, a}, q);
		bus(0, REG_CMD_OFS, 32'h0, q);
		check(q[31], 1'b1);
		wait_idle(n);
	endtask : run_op
	task automatic check_mac();
		int n;
		logic [31:0] q;
		bus(0, REG_CMD_OFS, 32'h0, q);
		check(q[31], 1'b1);
		wait_idle(n);
		for (int i = 0; i < MAC_BYTES; i++) check(mac_addr_out[i*8+:8], shadow[i]);
		check(mac_valid_out, 1'b1);
	endtask : check_mac
	initial begin
		logic [31:0] q;
		logic [7:0]  a, d;
		int          n;
		{avs_read_in, avs_write_in, avs_address_in, avs_writedata_in} = '0;
		{rst_in, present, slow, fails, comparisons} = {3'b110, 64'h0};
		avs_byteenable_in = 4'hF;
		for (int i = 0; i < 256; i++) shadow[i] = 8'(i * 37 + 8'h5A);
		void'($urandom(53));
		repeat (12) @(posedge mclk_in);
		rst_in <= 1'b0;
		check_mac();
		$display("test reset load done");
		for (int k = 0; k < 6; k++) begin
			a = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($urandom);
			run_op(SEC_OP_READ, a, 8'($urandom), n);
			bus(0, REG_DATA_OFS, 32'h0, q);
			check(q, {24'h0, shadow[a]});
		end
		$display("test reads done");
		for (int k = 0; k < 4; k++) begin
			slow = k[0];
			a = (k == 0) ? 8'h02 : 8'($urandom);
			d = 8'($urandom);
			run_op(SEC_OP_WRITE, a, d, n);
			shadow[a] = d;
			bus(0, REG_CMD_OFS, 32'h0, q);
			check(q[CMD_TMO_BIT], 1'b0);
			run_op(SEC_OP_READ, a, 8'h00, n);
			bus(0, REG_DATA_OFS, 32'h0, q);
			check(q, {24'h0, d});
		end
		bus(0, 8'hB8, 32'h0, q);
		check(q, 32'h0);
		// Start bit sits in byte lane 3, so a write without that lane starts nothing
		avs_byteenable_in <= 4'h7;
		bus(1, REG_CMD_OFS, {1'b1, 3'h0, 20'h0, 8'h10}, q);
		avs_byteenable_in <= 4'hF;
		bus(0, REG_CMD_OFS, 32'h0, q);
		check(q[31], 1'b0);
		// An opcode that is neither read nor write runs a frame and leaves the data word alone
		run_op(3'h2, 8'h21, 8'hA5, n);
		bus(0, REG_DATA_OFS, 32'h0, q);
		check(q, 32'h0000_00A5);
		$display("test writes done");
		present = 1'b0;
		run_op(SEC_OP_WRITE, 8'($urandom), 8'($urandom), n);
		check(n >= TMO, 1'b1);
		bus(0, REG_CMD_OFS, 32'h0, q);
		check(q[CMD_TMO_BIT], 1'b1);
		present = 1'b1;
		$display("test absent part done");
		@(posedge mclk_in);
		rst_in <= 1'b1;
		repeat (12) @(posedge mclk_in);
		rst_in <= 1'b0;
		check_mac();
		$display("test second reset done");
		conclude();
	end
endmodule : tb_sec_top
